// [design/ext_clk_regs.svh]
// register map, field positions, reset values and divider counts of the external clock control block
`ifndef EXT_CLK_REGS_SVH
`define EXT_CLK_REGS_SVH

`define ADDR_CTRL           4'h0
`define ADDR_STATUS         4'h4
`define ADDR_COUNT          4'h8

`define CTRL_EXT_GEN_ON     0
`define CTRL_INT_GEN_ON     1
`define CTRL_RESET          2'h2

`define ST_STABLE           0
`define ST_ACTIVE           1
`define ST_AMP_EN           2
`define ST_PATH_EN          3
`define ST_SLOW             4
`define ST_AMP_OPT          5
`define ST_ALLOW            6
`define ST_INACTIVE         7
`define ST_STOP             8
`define ST_EXT_REF          9
`define ST_INT_REF          10
`define ST_SETTLE           11

`define SETTLE_SHORT_M1     12'h00F
`define SETTLE_LONG_M1      12'hFFF
`define REF_EXT_LONG_M1     12'h07F
`define REF_INT_LONG_M1     12'hFFF
`define SETTLE_SHORT_BIT    3
`define SETTLE_LONG_BIT     11

`endif

// [design/ext_clk_pkg.sv]
// types shared by the external clock control block
package ext_clk_pkg;
   typedef enum logic {
      MODE_SETTLE,
      MODE_REF
   } div_mode_t;
   typedef logic [11:0] long_cnt_t;
endpackage

// [design/tick_if.sv]
// carrier for a slow clock seen as a level plus a one-cycle falling-edge tick
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   logic tick;
   logic level;
   modport src (output tick, output level);
   modport dst (input tick, input level);
endinterface
`default_nettype wire

// [design/edge_sync.sv]
// two-flop synchroniser with falling-edge tick for a pin or foreign clock
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_b,
   input  wire logic i_async,
   tick_if.src       o_sync
);
   logic meta;
   logic sync;
   logic prev;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= i_async;
         sync <= meta;
         prev <= sync;
      end
   end

   assign o_sync.level = sync;
   assign o_sync.tick  = prev & ~sync;
endmodule
`default_nettype wire

// [design/ref_divider.sv]
// divide-by-four stage: output toggles every second tick, held low while not running
`timescale 1ns/1ps
`default_nettype none
module ref_divider (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_b,
   tick_if.dst       i_src,
   output logic      o_ref
);
   logic [1:0] cnt;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b || !i_src.level) begin
         cnt <= 2'h0;
      end else if (i_src.tick) begin
         cnt <= cnt + 2'h1;
      end
   end

   assign o_ref = cnt[1];
endmodule
`default_nettype wire

// [design/ext_clock_gen_monitor_ref.sv]
// external clock generator control, stabilization timer and monitor reference dividers
//
// Summary of operation
// [RULE_01] slow crystal option selects reduced amplifier gain; clear selects full gain.
// [RULE_02] configuration must match slow crystal option to the attached crystal.
// [RULE_03] amplifier enabled only while generator active and crystal option set.
// [RULE_04] amplifier off returns oscillator output pin to port use.
// [RULE_05] input path enabled only while generator active; otherwise input pin is a port.
// [RULE_06] external reference from external clock, internal reference from base clock.
// [RULE_07] both clocks always divided by four; long divider chosen by slow option.
// [RULE_08] stable, slow clear: external ref divided 128*4, internal ref 1*4.
// [RULE_09] stable, slow set: external ref divided 1*4, internal ref 4096*4.
// [RULE_10] internal ref off with internal generator off; external ref off unless stable.
// [RULE_11] long divider doubles as settle timer, reset while generator inactive.
// [RULE_12] on enable, stable flag clear and external clock feeds long divider.
// [RULE_13] settle clock is external clock over 16, or 4096 with crystal option.
// [RULE_14] stable flag sets at settle clock fall after the full count.
// [RULE_15] once stable, long divider returns to making references.
// [RULE_16] stable cleared by inactivity returns long divider to settle timing.
// [RULE_17] software should switch monitor off after inactivity is detected.
// [RULE_18] generator active needs on bit and no stop; on bit needs clock allow.
// [RULE_19] stable flag clears on generator inactive or external inactivity.
// [RULE_20] options are static; divider selection changes only via stable flag.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ext_clk_regs.svh"
module ext_clock_gen_monitor_ref (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_b,
   // ahb-lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   // static configuration
   input  wire logic        i_slow_crystal_option,
   input  wire logic        i_crystal_amp_option,
   input  wire logic        i_ext_clock_allow,
   // foreign-domain inputs
   input  wire logic        i_ext_clock,
   input  wire logic        i_int_base_clock,
   input  wire logic        i_stop_request,
   input  wire logic        i_ext_inactive,
   // oscillator pad control
   output logic             o_amp_enable,
   output logic             o_amp_low_gain,
   output logic             o_osc_out_port_sel,
   output logic             o_osc_in_path_enable,
   output logic             o_osc_in_port_sel,
   // generator status and monitor references
   output logic             o_ext_gen_active,
   output logic             o_ext_clock_stable,
   output logic             o_ext_settle_clock,
   output logic             o_ext_monitor_ref,
   output logic             o_int_monitor_ref
);

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   localparam int N_SYNC = 4;

   logic [N_SYNC-1:0] async_in;
   logic [N_SYNC-1:0] sync_tick;
   logic [N_SYNC-1:0] sync_level;

   assign async_in = {i_ext_inactive, i_stop_request, i_int_base_clock, i_ext_clock};

   // both clocks are sampled by the system clock, so each must stay well below
   // half of 200 MHz; faster sources lose edges and slow the references down
   generate
      for (genvar g = 0; g < N_SYNC; g++) begin : g_sync
         tick_if sync_if ();
         edge_sync u_sync (
            .i_clk_sys (i_clk_sys),
            .i_rst_b   (i_rst_b),
            .i_async   (async_in[g]),
            .o_sync    (sync_if.src)
         );
         assign sync_tick[g]  = sync_if.tick;
         assign sync_level[g] = sync_if.level;
      end
   endgenerate

   wire ext_tick    = sync_tick[0];
   wire base_tick   = sync_tick[1];
   wire stop_sync   = sync_level[2];
   wire inact_sync  = sync_level[3];

   // ---------------------------------------------------------------
   // control register and generator enables
   // ---------------------------------------------------------------
   logic ext_gen_on;
   logic int_gen_on;
   logic ext_clock_stable;
   ext_clk_pkg::div_mode_t div_mode;
   ext_clk_pkg::long_cnt_t long_cnt;
   logic settle_clk;

   wire ext_gen_active = ext_gen_on & ~stop_sync; // RULE_18
   wire int_gen_active = int_gen_on & ~stop_sync;
   wire amp_enable     = ext_gen_active & i_crystal_amp_option; // RULE_03
   wire path_enable    = ext_gen_active; // RULE_05

   // ---------------------------------------------------------------
   // ahb-lite slave: zero wait states, always OKAY
   // ---------------------------------------------------------------
   logic       wr_pend;
   logic [3:0] wr_addr;
   logic [31:0] status_word;
   logic [31:0] rd_mux;

   wire addr_take   = i_hsel & i_htrans[1] & i_hready;
   wire sel_ctrl    = (i_haddr[3:0] == `ADDR_CTRL) & (i_haddr[31:4] == 28'h0);
   wire sel_status  = (i_haddr[3:0] == `ADDR_STATUS) & (i_haddr[31:4] == 28'h0);
   wire sel_count   = (i_haddr[3:0] == `ADDR_COUNT) & (i_haddr[31:4] == 28'h0);
   wire ctrl_write  = wr_pend & (wr_addr == `ADDR_CTRL);

   always_comb begin
      status_word                = 32'h0;
      status_word[`ST_STABLE]    = ext_clock_stable;
      status_word[`ST_ACTIVE]    = ext_gen_active;
      status_word[`ST_AMP_EN]    = amp_enable;
      status_word[`ST_PATH_EN]   = path_enable;
      status_word[`ST_SLOW]      = i_slow_crystal_option;
      status_word[`ST_AMP_OPT]   = i_crystal_amp_option;
      status_word[`ST_ALLOW]     = i_ext_clock_allow;
      status_word[`ST_INACTIVE]  = inact_sync;
      status_word[`ST_STOP]      = stop_sync;
      status_word[`ST_EXT_REF]   = o_ext_monitor_ref;
      status_word[`ST_INT_REF]   = o_int_monitor_ref;
      status_word[`ST_SETTLE]    = settle_clk;
   end

   assign rd_mux = sel_ctrl   ? {30'h0, int_gen_on, ext_gen_on} :
                   sel_status ? status_word :
                   sel_count  ? {20'h0, long_cnt} :
                   32'h0;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         wr_pend  <= 1'b0;
         wr_addr  <= 4'h0;
         o_hrdata <= 32'h0;
      end else if (addr_take) begin
         wr_pend  <= i_hwrite & sel_ctrl;
         wr_addr  <= i_haddr[3:0];
         o_hrdata <= i_hwrite ? 32'h0 : rd_mux;
      end else begin
         wr_pend  <= 1'b0;
      end
   end

   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

   // the on bit refuses to set while the external clock is not allowed
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         ext_gen_on <= 1'((`CTRL_RESET >> `CTRL_EXT_GEN_ON) & 2'h1);
         int_gen_on <= 1'((`CTRL_RESET >> `CTRL_INT_GEN_ON) & 2'h1);
      end else if (ctrl_write) begin
         ext_gen_on <= i_hwdata[`CTRL_EXT_GEN_ON] & i_ext_clock_allow; // RULE_18
         int_gen_on <= i_hwdata[`CTRL_INT_GEN_ON];
      end
   end

   // ---------------------------------------------------------------
   // shared long divider: settle timer or reference divider
   // ---------------------------------------------------------------
   ext_clk_pkg::div_mode_t want_mode;
   ext_clk_pkg::long_cnt_t limit_m1;
   ext_clk_pkg::long_cnt_t next_long_cnt;
   logic long_src_tick;
   logic long_wrap;
   logic settle_hi;
   logic next_stable;

   // mode follows the stable flag only; options are taken as static straps
   assign want_mode = ext_clock_stable ? ext_clk_pkg::MODE_REF
                                       : ext_clk_pkg::MODE_SETTLE; // RULE_15 RULE_16 RULE_20

   wire in_settle = (div_mode == ext_clk_pkg::MODE_SETTLE);

   always_comb begin
      case (div_mode)
         ext_clk_pkg::MODE_SETTLE: begin
            limit_m1      = i_crystal_amp_option ? `SETTLE_LONG_M1 : `SETTLE_SHORT_M1; // RULE_13
            long_src_tick = ext_tick; // RULE_12
         end
         ext_clk_pkg::MODE_REF: begin
            limit_m1      = i_slow_crystal_option ? `REF_INT_LONG_M1 : `REF_EXT_LONG_M1; // RULE_07
            long_src_tick = i_slow_crystal_option ? base_tick : ext_tick; // RULE_07
         end
         default: begin
            limit_m1      = `SETTLE_SHORT_M1;
            long_src_tick = 1'b0;
         end
      endcase
   end

   assign long_wrap = long_src_tick & (long_cnt == limit_m1);

   always_comb begin
      if (!ext_gen_active || (div_mode != want_mode)) begin
         next_long_cnt = 12'h000; // RULE_11
      end else if (long_src_tick) begin
         next_long_cnt = long_wrap ? 12'h000 : long_cnt + 12'h001;
      end else begin
         next_long_cnt = long_cnt;
      end
   end

   // upper half of the count is the high phase; the wrap is its falling edge
   assign settle_hi = i_crystal_amp_option ? long_cnt[`SETTLE_LONG_BIT]
                                           : long_cnt[`SETTLE_SHORT_BIT];

   // set wins over a clear that lands in the same cycle
   always_comb begin
      if (ext_gen_active && in_settle && long_wrap) begin
         next_stable = 1'b1; // RULE_14
      end else if (!ext_gen_active || inact_sync) begin
         next_stable = 1'b0; // RULE_19
      end else begin
         next_stable = ext_clock_stable;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         long_cnt         <= 12'h000;
         div_mode         <= ext_clk_pkg::MODE_SETTLE;
         ext_clock_stable <= 1'b0;
         settle_clk       <= 1'b0;
      end else begin
         long_cnt         <= next_long_cnt;
         div_mode         <= want_mode;
         ext_clock_stable <= next_stable;
         settle_clk       <= ext_gen_active & in_settle & settle_hi; // RULE_13
      end
   end

   // ---------------------------------------------------------------
   // monitor references: fixed divide-by-four after an optional long stage
   // ---------------------------------------------------------------
   wire ref_long = ~in_settle & ext_clock_stable;
   wire ext_ref_tick = i_slow_crystal_option ? ext_tick : (ref_long & long_wrap); // RULE_08 RULE_09
   wire int_ref_tick = i_slow_crystal_option ? (ref_long & long_wrap) : base_tick; // RULE_08 RULE_09
   wire int_ref_from_base = ~(i_slow_crystal_option & ref_long);

   tick_if ext_ref_if ();
   tick_if int_ref_if ();

   assign ext_ref_if.tick  = ext_ref_tick; // RULE_06
   assign ext_ref_if.level = ref_long & ext_gen_active; // RULE_10
   // while settling in slow mode the base clock drives the internal reference directly
   assign int_ref_if.tick  = int_ref_from_base ? base_tick : int_ref_tick; // RULE_06
   assign int_ref_if.level = int_gen_active; // RULE_10

   logic ext_ref_raw;
   logic int_ref_raw;

   ref_divider u_ext_ref_div (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_src     (ext_ref_if.dst),
      .o_ref     (ext_ref_raw)
   );

   ref_divider u_int_ref_div (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_src     (int_ref_if.dst),
      .o_ref     (int_ref_raw)
   );

   // ---------------------------------------------------------------
   // registered pad controls and status outputs
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_amp_enable         <= 1'b0;
         o_amp_low_gain       <= 1'b0;
         o_osc_out_port_sel   <= 1'b1;
         o_osc_in_path_enable <= 1'b0;
         o_osc_in_port_sel    <= 1'b1;
         o_ext_gen_active     <= 1'b0;
         o_ext_clock_stable   <= 1'b0;
         o_ext_settle_clock   <= 1'b0;
         o_ext_monitor_ref    <= 1'b0;
         o_int_monitor_ref    <= 1'b0;
      end else begin
         o_amp_enable         <= amp_enable; // RULE_03
         o_amp_low_gain       <= i_slow_crystal_option; // RULE_01
         o_osc_out_port_sel   <= ~amp_enable; // RULE_04
         o_osc_in_path_enable <= path_enable; // RULE_05
         o_osc_in_port_sel    <= ~path_enable; // RULE_05
         o_ext_gen_active     <= ext_gen_active;
         o_ext_clock_stable   <= ext_clock_stable;
         o_ext_settle_clock   <= settle_clk;
         o_ext_monitor_ref    <= ext_ref_raw;
         o_int_monitor_ref    <= int_ref_raw;
      end
   end

   // transfer size is not checked: only whole-word accesses are supported
   logic unused_ok;
   assign unused_ok = &{1'b0, i_hsize, i_haddr[1:0], i_hwdata[31:2]};

endmodule
`default_nettype wire

// [bench/ext_clock_gen_monitor_ref_asserts.sv]
// port-level checks for the external clock control block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module ext_clock_gen_monitor_ref_asserts (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_slow_crystal_option,
   input wire logic i_crystal_amp_option,
   input wire logic i_stop_request,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic o_amp_enable,
   input wire logic o_amp_low_gain,
   input wire logic o_osc_out_port_sel,
   input wire logic o_osc_in_path_enable,
   input wire logic o_osc_in_port_sel,
   input wire logic o_ext_gen_active,
   input wire logic o_ext_clock_stable,
   input wire logic o_ext_settle_clock,
   input wire logic o_ext_monitor_ref
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   bus_okay_a: assert property (o_hreadyout && !o_hresp)
      else $error("bus answer not ready and okay");
   // straps are static, so after one settled cycle the gain copy must match
   gain_copy_a: assert property ($past(i_rst_b) |-> o_amp_low_gain == i_slow_crystal_option)
      else $error("amplifier gain does not follow slow option");
   amp_gate_a: assert property (o_amp_enable |-> i_crystal_amp_option && (o_ext_gen_active || $past(o_ext_gen_active)))
      else $error("amplifier on without active generator and option");
   amp_on_a: assert property ((i_crystal_amp_option && o_ext_gen_active) [*2] |-> o_amp_enable)
      else $error("amplifier stays off while wanted");
   out_port_a: assert property (o_osc_out_port_sel == !o_amp_enable)
      else $error("output pin port select wrong");
   in_path_a: assert property (o_osc_in_path_enable == o_ext_gen_active && o_osc_in_port_sel == !o_osc_in_path_enable)
      else $error("input pin path select wrong");
   stop_idle_a: assert property (i_stop_request [*4] |-> !o_ext_gen_active)
      else $error("generator active during stop");
   stable_drop_a: assert property (!o_ext_gen_active [*3] |-> !o_ext_clock_stable)
      else $error("stable flag held while generator inactive");
   stable_rise_a: assert property ($rose(o_ext_clock_stable) |-> o_ext_gen_active)
      else $error("stable flag set while generator inactive");
   ext_ref_off_a: assert property (!o_ext_clock_stable [*4] |-> !o_ext_monitor_ref)
      else $error("external reference runs before stable");
   settle_off_a: assert property (o_ext_clock_stable [*3] |-> !o_ext_settle_clock)
      else $error("settle clock runs after stable");
endmodule
bind ext_clock_gen_monitor_ref ext_clock_gen_monitor_ref_asserts u_asserts (.*);
`default_nettype wire

// [bench/ext_osc_model.sv]
// crystal or clock source model: toggles every HALF system cycles while run is high
`timescale 1ns/1ps
`default_nettype none
module ext_osc_model #(
   parameter int HALF = 3
) (
   input  wire logic i_clk_sys,
   input  wire logic i_run,
   output logic      o_clk
);
   int n;
   initial begin
      o_clk = 1'b0;
      n = 0;
   end
   // a source whose oscillator input path is off stands still
   always @(posedge i_clk_sys) begin
      if (!i_run) begin
         n <= 0;
         o_clk <= 1'b0;
      end else if (n == HALF - 1) begin
         n <= 0;
         o_clk <= !o_clk;
      end else begin
         n <= n + 1;
      end
   end
endmodule
`default_nettype wire

// [bench/tb_ext_clock_gen_monitor_ref.sv]
// self-checking bench for the external clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_ext_clock_gen_monitor_ref;
   logic        i_clk_sys = 1'b0;
   logic        i_rst_b = 1'b0;
   logic        i_hsel = 1'b0;
   logic [31:0] i_haddr = 32'h0;
   logic [1:0]  i_htrans = 2'h0;
   logic        i_hwrite = 1'b0;
   logic [2:0]  i_hsize = 3'h2;
   logic [31:0] i_hwdata = 32'h0;
   logic        i_hready;
   logic        o_hreadyout, o_hresp;
   logic [31:0] o_hrdata;
   logic        i_slow_crystal_option = 1'b0;
   logic        i_crystal_amp_option = 1'b0;
   logic        i_ext_clock_allow = 1'b1;
   logic        i_ext_clock, i_int_base_clock;
   logic        i_stop_request = 1'b0;
   logic        i_ext_inactive = 1'b0;
   logic        o_amp_enable, o_amp_low_gain, o_osc_out_port_sel, o_osc_in_path_enable, o_osc_in_port_sel;
   logic        o_ext_gen_active, o_ext_clock_stable, o_ext_settle_clock, o_ext_monitor_ref, o_int_monitor_ref;
   int          fails = 0;
   int          samples_checked = 0;
   int          seed = 32'hF0A7;
   int          n;
   logic [31:0] r;
   assign i_hready = o_hreadyout;
   always #2.5 i_clk_sys = !i_clk_sys;
   ext_clock_gen_monitor_ref u_dut (.*);
   ext_osc_model #(.HALF(3)) u_xtal (.i_clk_sys(i_clk_sys), .i_run(o_osc_in_path_enable), .o_clk(i_ext_clock));
   ext_osc_model #(.HALF(2)) u_base (.i_clk_sys(i_clk_sys), .i_run(1'b1), .o_clk(i_int_base_clock));

   function automatic logic [31:0] rnd();
      return $random(seed);
   endfunction
   function automatic logic pick(input int i);
      case (i)
         0: return i_ext_clock;
         1: return i_int_base_clock;
         2: return o_ext_clock_stable;
         3: return o_ext_monitor_ref;
         default: return o_int_monitor_ref;
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one single transfer; the master waits on hready in both phases
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
      int k;
      k = 0;
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_hwrite <= wr;
      i_htrans <= 2'h2;
      @(posedge i_clk_sys);
      while (i_hready !== 1'b1 && k < 100) begin
         @(posedge i_clk_sys);
         k++;
      end
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      @(posedge i_clk_sys);
      while (i_hready !== 1'b1 && k < 200) begin
         @(posedge i_clk_sys);
         k++;
      end
      rd = o_hrdata;
   endtask
   // counts source falls until the target rises, or until lim falls pass
   task automatic falls_until(input int src, input int tgt, input int lim, output int cnt);
      logic ps, pt;
      cnt = 0;
      do begin
         ps = pick(src);
         pt = pick(tgt);
         @(posedge i_clk_sys);
         if (ps === 1'b1 && pick(src) === 1'b0) cnt++;
      end while (cnt < lim && !(pt === 1'b0 && pick(tgt) === 1'b1));
   endtask
   task automatic restart(input logic s, input logic a, input logic al);
      i_rst_b <= 1'b0;
      i_slow_crystal_option <= s;
      i_crystal_amp_option <= a;
      i_ext_clock_allow <= al;
      repeat (2) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      @(posedge i_clk_sys);
   endtask
   task automatic settle_case(input logic s, input logic a);
      int lim;
      lim = a ? 4096 : 16;
      restart(s, a, 1'b1);
      check({o_osc_out_port_sel, o_osc_in_port_sel, o_amp_enable}, 3'h6);
      ahb(1'b1, 32'h0, rnd() | 32'h3, r);
      falls_until(0, 2, 5000, n);
      check(n >= lim && n <= lim + 1, 1'b1);
      repeat (4) @(posedge i_clk_sys);
      check({o_amp_enable, o_osc_out_port_sel, o_osc_in_path_enable, o_osc_in_port_sel, o_amp_low_gain}, {a, !a, 2'b10, s});
      ahb(1'b0, 32'h4, 32'h0, r);
      check(r[6:0], {1'b1, a, s, 1'b1, a, 2'b11});
      falls_until(0, 3, 2000, n);
      falls_until(0, 3, 2000, n);
      check(n, s ? 4 : 512);
      // a slow-mode internal period far exceeds the window, so the count saturates
      falls_until(1, 4, 600, n);
      falls_until(1, 4, 600, n);
      check(n, s ? 600 : 4);
      check(o_ext_settle_clock, 1'b0);
      i_stop_request <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
      check({o_ext_gen_active, o_ext_clock_stable, o_amp_enable}, 3'h0);
      ahb(1'b0, 32'h8, 32'h0, r);
      check(r, 32'h0);
      i_stop_request <= 1'b0;
      if (!a) begin
         falls_until(0, 2, 5000, n);
         check(n >= lim && n <= lim + 1, 1'b1);
         // no monitor sits in this bench, so nothing has to be switched off here
         i_ext_inactive <= 1'b1;
         repeat (6) @(posedge i_clk_sys);
         check(o_ext_clock_stable, 1'b0);
         i_ext_inactive <= 1'b0;
         falls_until(0, 2, 5000, n);
         check(n + 2 >= lim && n <= lim + 1, 1'b1);
      end
   endtask

   initial begin
      repeat (2) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      @(posedge i_clk_sys);
      ahb(1'b1, 32'h4, 32'hFFFFFFFF, r);
      ahb(1'b0, 32'h0, 32'h0, r);
      check(r, 32'h2);
      ahb(1'b0, 32'h10, 32'h0, r);
      check(r, 32'h0);
      restart(1'b0, 1'b0, 1'b0);
      ahb(1'b1, 32'h0, 32'h3, r);
      ahb(1'b0, 32'h0, 32'h0, r);
      check(r, 32'h2);
      check(o_ext_gen_active, 1'b0);
      for (int k = 0; k < 4; k++) settle_case(k[0], k[1]);
      ahb(1'b1, 32'h0, rnd() & 32'hFFFFFFFC, r);
      repeat (8) @(posedge i_clk_sys);
      check({o_ext_clock_stable, o_osc_in_path_enable, o_ext_monitor_ref}, 3'h0);
      falls_until(1, 4, 50, n);
      check(n, 50);
      final_report();
   end
   initial begin
      // the two crystal-option cases settle over 4096 edges each and dominate the run
      repeat (95000) @(posedge i_clk_sys);
      fails++;
      $display("[FAIL] %0t run did not finish in time", $time);
      final_report();
   end
endmodule
`default_nettype wire
